//--- common/crs_pkg.sv
// Package with register map, field positions, reset values and timing counts.
package crs_pkg;
  localparam logic [11:0] ADDR_STATUS   = 12'h00c;
  localparam logic [11:0] ADDR_PC       = 12'h010;
  localparam logic [11:0] ADDR_INSTR    = 12'h014;
  localparam logic [11:0] ADDR_EVENT    = 12'h018;
  localparam logic [11:0] ADDR_MASK     = 12'h01c;
  localparam logic [11:0] ADDR_CTRL     = 12'h020;
  localparam logic [11:0] ADDR_ACC      = 12'h024;
  localparam logic [11:0] ADDR_FILE     = 12'h028;
  localparam int          TO_BIT        = 4;
  localparam int          PD_BIT        = 3;
  localparam int          PAGE_LO       = 5;
  localparam logic [7:0]  STATUS_POR    = 8'h18;
  localparam logic [4:0]  PCL_FILE_ADDR = 5'h02;
  localparam logic [4:0]  STAT_FILE_ADDR = 5'h03;
  localparam logic [10:0] RESET_VECTOR  = 11'h7ff;
  localparam int          CLK_HZ        = 10000000;
  localparam int          DRT_MS        = 18;
  localparam int          WDT_MS        = 18;
  localparam int          WDT_RC_HZ     = 10000;
  localparam int          DRT_CYCLES    = (DRT_MS * (CLK_HZ / 1000));
  localparam int          WDT_TICKS     = (WDT_MS * WDT_RC_HZ) / 1000;
  localparam int          EV_POR        = 0;
  localparam int          EV_MASTER_CLEAR       = 1;
  localparam int          EV_MASTER_CLEAR_WAKE  = 2;
  localparam int          EV_WDT        = 3;
  localparam int          EV_WDT_WAKE   = 4;
  typedef enum logic [1:0] {CRS_HOLD, CRS_RUN, CRS_SLEEP, CRS_WAIT2} crs_state_type;
endpackage

//--- design/crs_core.sv
// Reset source recorder, program counter sequencer and watchdog of the core.
`timescale 1ns/1ps
module crs_core #(
  parameter int DRT_COUNT = crs_pkg::DRT_CYCLES,
  parameter int WDT_COUNT = crs_pkg::WDT_TICKS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_clear_n,
  input  wire logic        watchdog_enable_fuse,
  input  wire logic        wdt_rc_clk,
  input  wire logic [10:0] top_of_stack,
  output logic [10:0]      program_counter,
  output logic             core_running,
  output logic             in_sleep,
  output logic             irq
);
  crs_pkg::crs_state_type state;
  logic [7:0]  core_status;
  logic [10:0] pc;
  logic [7:0]  acc;
  logic [7:0]  file_last;
  logic [4:0]  file_addr_last;
  logic [4:0]  events;
  logic [4:0]  mask;
  logic        sleep_req;
  logic [31:0] drt_cnt;
  logic [15:0] wdt_cnt;
  logic        wdt_tog;
  logic        wdt_s1;
  logic        wdt_s2;
  logic        wdt_s3;
  logic        master_clear_d;
  logic        por_done;
  logic        rst_pending;
  logic        rst_wake;
  logic        rst_wdt;
  logic [11:0] instr;
  logic        instr_valid;
  // Register bus decode.
  wire         wr_en        = psel && penable && pwrite;
  wire         hit_status   = (paddr == crs_pkg::ADDR_STATUS);
  wire         hit_pc       = (paddr == crs_pkg::ADDR_PC);
  wire         hit_instr    = (paddr == crs_pkg::ADDR_INSTR);
  wire         hit_event    = (paddr == crs_pkg::ADDR_EVENT);
  wire         hit_mask     = (paddr == crs_pkg::ADDR_MASK);
  wire         hit_ctrl     = (paddr == crs_pkg::ADDR_CTRL);
  wire         hit_acc      = (paddr == crs_pkg::ADDR_ACC);
  wire         hit_file     = (paddr == crs_pkg::ADDR_FILE);
  wire         hit_any      = hit_status | hit_pc | hit_instr | hit_event | hit_mask |
                              hit_ctrl | hit_acc | hit_file;
  wire         instr_wr     = wr_en && hit_instr && (state == crs_pkg::CRS_RUN);
  wire [11:0]  op           = pwdata[11:0];
  // Instruction decode.
  wire         is_direct_jump      = (op[11:9] == 3'b101);
  wire         is_call      = (op[11:8] == 4'b1001);
  wire         is_return_with_literal     = (op[11:8] == 4'b1000);
  wire         is_move_acc_to_file     = (op[11:5] == 7'b0000001);
  wire         is_add_acc_to_file_f   = (op[11:6] == 6'b000111) && op[5];
  wire         is_bsf       = (op[11:8] == 4'b0101);
  wire         is_sleep     = (op == 12'h003);
  wire         to_pcl       = (op[4:0] == crs_pkg::PCL_FILE_ADDR);
  wire         pcl_mod      = (is_move_acc_to_file | is_add_acc_to_file_f | is_bsf) && to_pcl;
  wire [7:0]   add_res      = acc + pc[7:0];
  wire [7:0]   bsf_res      = pc[7:0] | (8'h01 << op[7:5]);
  wire [7:0]   pcl_res      = is_move_acc_to_file ? acc : (is_add_acc_to_file_f ? add_res : bsf_res);
  wire [1:0]   page         = core_status[6:5];
  wire [10:0]  pc_inc       = pc + 11'h001;
  wire         wdt_tick     = wdt_s2 ^ wdt_s3;
  wire         wdt_expire   = watchdog_enable_fuse && wdt_tick &&
                              (wdt_cnt == 16'(WDT_COUNT - 1));
  wire         master_clear_fall    = master_clear_d && !master_clear_n;
  logic [10:0] next_pc;

  always_comb
  begin
    next_pc = pc_inc;
    if (is_direct_jump)
      next_pc = {page, op[8:0]};
    else if (is_call)
      next_pc = {page, 1'b0, op[7:0]};
    else if (pcl_mod)
      next_pc = {page, 1'b0, pcl_res};
    else if (is_return_with_literal)
      next_pc = top_of_stack;
  end

  assign program_counter = pc;
  assign core_running    = (state == crs_pkg::CRS_RUN);
  assign in_sleep        = (state == crs_pkg::CRS_SLEEP);
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !hit_any;
  assign irq             = |(events & mask);

  // Watchdog on its own oscillator, crossed as a toggle.
  always_ff @(posedge wdt_rc_clk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_tog <= 1'b0;
    end
    else
    begin
      wdt_tog <= ~wdt_tog;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_s1 <= 1'b0;
      wdt_s2 <= 1'b0;
      wdt_s3 <= 1'b0;
      master_clear_d <= 1'b1;
    end
    else
    begin
      wdt_s1 <= wdt_tog;
      wdt_s2 <= wdt_s1;
      wdt_s3 <= wdt_s2;
      master_clear_d <= master_clear_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_cnt <= 16'h0000;
    else if (state == crs_pkg::CRS_HOLD || instr_wr && op == 12'h004 || wdt_expire)
      wdt_cnt <= 16'h0000;
    else if (wdt_tick && watchdog_enable_fuse)
      wdt_cnt <= wdt_cnt + 16'h0001;
  end

  // Reset sequencing and status flags.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= crs_pkg::CRS_HOLD;
      drt_cnt     <= 32'h0;
      por_done    <= 1'b0;
      rst_pending <= 1'b1;
      rst_wake    <= 1'b0;
      rst_wdt     <= 1'b0;
      core_status <= crs_pkg::STATUS_POR;
      pc          <= crs_pkg::RESET_VECTOR;
      sleep_req   <= 1'b0;
    end
    else
    begin
      case (state)
        crs_pkg::CRS_HOLD:
        begin
          if (!master_clear_n)
            drt_cnt <= 32'h0;
          else if (drt_cnt == 32'(DRT_COUNT - 1))
          begin
            state   <= crs_pkg::CRS_RUN;
            drt_cnt <= 32'h0;
          end
          else
            drt_cnt <= drt_cnt + 32'h1;
          if (rst_pending && por_done)
          begin
            core_status[7:5] <= 3'b000;
            if (rst_wake || rst_wdt)
            begin
              core_status[crs_pkg::TO_BIT] <= !rst_wdt;
              core_status[crs_pkg::PD_BIT] <= !rst_wake;
            end
          end
          rst_pending <= 1'b0;
          pc          <= crs_pkg::RESET_VECTOR;
        end
        crs_pkg::CRS_RUN:
        begin
          por_done <= 1'b1;
          if (master_clear_fall || wdt_expire)
          begin
            state       <= crs_pkg::CRS_HOLD;
            rst_pending <= 1'b1;
            rst_wake    <= 1'b0;
            rst_wdt     <= wdt_expire && !master_clear_fall;
            drt_cnt     <= 32'h0;
          end
          else if (instr_wr)
          begin
            pc <= next_pc;
            if (is_sleep)
            begin
              state                        <= crs_pkg::CRS_SLEEP;
              core_status[crs_pkg::PD_BIT] <= 1'b0;
              core_status[crs_pkg::TO_BIT] <= 1'b1;
            end
            else if (is_return_with_literal)
              state <= crs_pkg::CRS_WAIT2;
            else if (is_move_acc_to_file && op[4:0] == crs_pkg::STAT_FILE_ADDR)
              core_status <= acc;
          end
          else if (wr_en && hit_pc)
            pc <= {pc[10:8], pwdata[7:0]};
          else if (wr_en && hit_status)
            core_status <= {pwdata[7:5], core_status[4:3], pwdata[2:0]};
        end
        crs_pkg::CRS_WAIT2:
          state <= crs_pkg::CRS_RUN;
        crs_pkg::CRS_SLEEP:
        begin
          if (master_clear_fall || wdt_expire)
          begin
            state       <= crs_pkg::CRS_HOLD;
            rst_pending <= 1'b1;
            rst_wake    <= 1'b1;
            rst_wdt     <= wdt_expire && !master_clear_fall;
            drt_cnt     <= 32'h0;
          end
        end
        default:
          state <= crs_pkg::CRS_HOLD;
      endcase
    end
  end

  // Accumulator and file copy; these are not touched by reset after power-on.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc            <= 8'h00;
      file_last      <= 8'h00;
      file_addr_last <= 5'h00;
    end
    else if (wr_en && hit_acc && state == crs_pkg::CRS_RUN)
      acc <= pwdata[7:0];
    else if (instr_wr && is_return_with_literal)
      acc <= op[7:0];
    else if (instr_wr && is_move_acc_to_file)
    begin
      file_last      <= acc;
      file_addr_last <= op[4:0];
    end
  end

  // Sticky reset-source events and mask.
  wire         ev_wdt_run   = (state == crs_pkg::CRS_RUN) && wdt_expire;
  wire         ev_master_clear_run  = (state == crs_pkg::CRS_RUN) && master_clear_fall;
  wire         ev_wdt_wake  = in_sleep && wdt_expire && !master_clear_fall;
  wire         ev_master_clear_wake = in_sleep && master_clear_fall;
  wire [4:0]   ev_set       = {ev_wdt_wake, ev_wdt_run && !master_clear_fall, ev_master_clear_wake,
                               ev_master_clear_run, 1'b0};
  wire [4:0]   ev_clr       = (wr_en && hit_event) ? pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      events <= 5'h01;
      mask   <= 5'h00;
    end
    else
    begin
      events <= (events & ~ev_clr) | ev_set;
      if (wr_en && hit_mask)
        mask <= pwdata[4:0];
    end
  end

  always_comb
  begin
    prdata = 32'h0;
    if (hit_status)
      prdata = {24'h0, core_status};
    else if (hit_pc)
      prdata = {21'h0, pc};
    else if (hit_event)
      prdata = {27'h0, events};
    else if (hit_mask)
      prdata = {27'h0, mask};
    else if (hit_ctrl)
      prdata = {28'h0, watchdog_enable_fuse, in_sleep, core_running, state == crs_pkg::CRS_WAIT2};
    else if (hit_acc)
      prdata = {24'h0, acc};
    else if (hit_file)
      prdata = {19'h0, file_addr_last, file_last};
  end

  a_wake_flags: assert property (@(posedge pclk) disable iff (!presetn)
    in_sleep && wdt_expire && !master_clear_fall |=> ##1 core_status[4:3] == 2'b00)
    else $error("watchdog wake flags wrong");
  a_pc_inc: assert property (@(posedge pclk) disable iff (!presetn)
    instr_wr && op == 12'h000 && !master_clear_fall && !wdt_expire |=> pc == $past(pc) + 11'h001)
    else $error("counter did not advance");
  a_direct_jump_load: assert property (@(posedge pclk) disable iff (!presetn)
    instr_wr && is_direct_jump && !master_clear_fall && !wdt_expire |=> pc[8:0] == $past(op[8:0]))
    else $error("direct jump load wrong");
  a_call_bit8: assert property (@(posedge pclk) disable iff (!presetn)
    instr_wr && (is_call || pcl_mod) && !master_clear_fall && !wdt_expire |=> !pc[8])
    else $error("counter bit 8 not cleared");
  a_page_bits: assert property (@(posedge pclk) disable iff (!presetn)
    instr_wr && is_direct_jump && !master_clear_fall && !wdt_expire |=> pc[10:9] == $past(core_status[6:5]))
    else $error("page bits not applied");
  a_return_with_literal_two: assert property (@(posedge pclk) disable iff (!presetn)
    instr_wr && is_return_with_literal && !master_clear_fall && !wdt_expire |=> !core_running ##1 core_running)
    else $error("return not two cycles");
  a_sleep_stay: assert property (@(posedge pclk) disable iff (!presetn)
    in_sleep && !master_clear_fall && !wdt_expire |=> in_sleep)
    else $error("left sleep without cause");
  a_wake_reset: assert property (@(posedge pclk) disable iff (!presetn)
    in_sleep && master_clear_fall |=> state == crs_pkg::CRS_HOLD ##1 pc == crs_pkg::RESET_VECTOR)
    else $error("wake did not reset");
  a_reset_page: assert property (@(posedge pclk) disable iff (!presetn)
    state == crs_pkg::CRS_HOLD && rst_pending && por_done |=> core_status[7:5] == 3'b000)
    else $error("page bits not cleared");
  c_wdt_wake: cover property (@(posedge pclk) disable iff (!presetn) ev_wdt_wake);
  c_master_clear_wake: cover property (@(posedge pclk) disable iff (!presetn) ev_master_clear_wake);
  c_pcl_jump: cover property (@(posedge pclk) disable iff (!presetn) instr_wr && pcl_mod);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule

//--- bench/cpu_reset_and_pc_sequencer_bench.sv
// Self-checking bench for the core reset recorder and program counter sequencer.
`timescale 1ns/1ps
module cpu_reset_and_pc_sequencer_bench;
  localparam int DRT_N = 20;
  localparam int WDT_N = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        master_clear_n = 1'b1;
  logic        watchdog_enable_fuse = 1'b0;
  logic        wdt_rc_clk = 1'b0;
  logic [10:0] top_of_stack = 11'h3a5;
  logic [10:0] program_counter;
  logic        core_running;
  logic        in_sleep;
  logic        irq;
  logic [31:0] rd;
  logic        err_seen;
  int          err_count = 0;
  int          compares = 0;

  always #50 pclk = ~pclk;
  always #1000 wdt_rc_clk = ~wdt_rc_clk;

  crs_core #(.DRT_COUNT(DRT_N), .WDT_COUNT(WDT_N)) u_dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .master_clear_n       (master_clear_n),
    .watchdog_enable_fuse (watchdog_enable_fuse),
    .wdt_rc_clk           (wdt_rc_clk),
    .top_of_stack         (top_of_stack),
    .program_counter      (program_counter),
    .core_running         (core_running),
    .in_sleep             (in_sleep),
    .irq                  (irq)
  );

  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20)
    begin
      err_count++;
      wrap_up();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the edge's updates settle before any caller looks at outputs.
    @(negedge pclk);
  endtask

  task automatic rd_check(input string what, input logic [11:0] addr,
                          input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, addr, 32'h0);
    check(what, exp & mask, rd & mask);
  endtask

  task automatic exec(input logic [11:0] op);
    apb(1'b1, crs_pkg::ADDR_INSTR, {20'h0, op});
  endtask

  task automatic wait_state(input logic [1:0] want);
    int n;
    n = 0;
    while ({core_running, in_sleep} !== want && n < 3000)
    begin
      n++;
      @(posedge pclk);
    end
    check("core state", {30'h0, want}, {30'h0, core_running, in_sleep});
    if (n >= 3000)
    begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic pulse_clear();
    @(posedge pclk);
    master_clear_n <= 1'b0;
    repeat (3) @(posedge pclk);
    master_clear_n <= 1'b1;
    @(posedge pclk);
    wait_state(2'b10);
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (DRT_N - 3) @(posedge pclk);
    check("running in hold", 32'h0, {31'h0, core_running});
    wait_state(2'b10);
    rd_check("status por", crs_pkg::ADDR_STATUS, 32'h18, 32'hf8);
    rd_check("events por", crs_pkg::ADDR_EVENT, 32'h01, 32'h1f);
    rd_check("pc por", crs_pkg::ADDR_PC, 32'h7ff, 32'h7ff);
    exec(12'h000);
    rd_check("pc wrap", crs_pkg::ADDR_PC, 32'h000, 32'h7ff);
    exec(12'h000);
    rd_check("pc inc", crs_pkg::ADDR_PC, 32'h001, 32'h7ff);
    apb(1'b1, crs_pkg::ADDR_STATUS, 32'h60);
    exec(12'hbab);
    rd_check("pc jump", crs_pkg::ADDR_PC, 32'h7ab, 32'h7ff);
    exec(12'h9c5);
    rd_check("pc call", crs_pkg::ADDR_PC, 32'h6c5, 32'h7ff);
    apb(1'b1, crs_pkg::ADDR_STATUS, 32'h00);
    apb(1'b1, crs_pkg::ADDR_ACC, 32'h13);
    exec(12'h022);
    rd_check("pc move latch", crs_pkg::ADDR_PC, 32'h013, 32'h7ff);
    exec(12'h5a2);
    rd_check("pc bit set latch", crs_pkg::ADDR_PC, 32'h033, 32'h7ff);
    exec(12'h1e2);
    rd_check("pc add latch", crs_pkg::ADDR_PC, 32'h046, 32'h7ff);
    apb(1'b1, crs_pkg::ADDR_STATUS, 32'h07);
    exec(12'h025);
    rd_check("file copy", crs_pkg::ADDR_FILE, 32'h0513, 32'h1fff);
    rd_check("status kept", crs_pkg::ADDR_STATUS, 32'h1f, 32'hff);
    exec(12'h85a);
    rd_check("acc literal", crs_pkg::ADDR_ACC, 32'h5a, 32'hff);
    rd_check("pc popped", crs_pkg::ADDR_PC, 32'h3a5, 32'h7ff);
    wait_state(2'b10);
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, crs_pkg::ADDR_MASK, 32'h1f);
    check("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, crs_pkg::ADDR_EVENT, 32'h1f);
    rd_check("events clear", crs_pkg::ADDR_EVENT, 32'h0, 32'h1f);
    check("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err_seen});
    exec(12'h003);
    exec(12'h000);
    wait_state(2'b01);
    pulse_clear();
    rd_check("status clear wake", crs_pkg::ADDR_STATUS, 32'h17, 32'hff);
    rd_check("events clear wake", crs_pkg::ADDR_EVENT, 32'h04, 32'h1f);
    rd_check("pc after wake", crs_pkg::ADDR_PC, 32'h7ff, 32'h7ff);
    rd_check("acc kept", crs_pkg::ADDR_ACC, 32'h5a, 32'hff);
    check("irq event", 32'h1, {31'h0, irq});
    apb(1'b1, crs_pkg::ADDR_EVENT, 32'h1f);
    apb(1'b1, crs_pkg::ADDR_STATUS, 32'h62);
    pulse_clear();
    rd_check("status clear run", crs_pkg::ADDR_STATUS, 32'h12, 32'hff);
    rd_check("events clear run", crs_pkg::ADDR_EVENT, 32'h02, 32'h1f);
    apb(1'b1, crs_pkg::ADDR_EVENT, 32'h1f);
    watchdog_enable_fuse <= 1'b1;
    wait_state(2'b00);
    wait_state(2'b10);
    exec(12'h004);
    rd_check("status dog run", crs_pkg::ADDR_STATUS, 32'h0a, 32'hff);
    rd_check("events dog run", crs_pkg::ADDR_EVENT, 32'h08, 32'h1f);
    apb(1'b1, crs_pkg::ADDR_EVENT, 32'h1f);
    exec(12'h003);
    wait_state(2'b01);
    wait_state(2'b00);
    wait_state(2'b10);
    rd_check("status dog wake", crs_pkg::ADDR_STATUS, 32'h02, 32'hff);
    rd_check("events dog wake", crs_pkg::ADDR_EVENT, 32'h10, 32'h1f);
    watchdog_enable_fuse <= 1'b0;
    exec(12'h003);
    repeat (300) @(posedge pclk);
    check("sleep without dog", 32'h1, {31'h0, in_sleep});
    pulse_clear();
    wrap_up();
  end
endmodule
